//--- rtl/edge_logic_pkg.sv
// shared constants and carriers for the edge counter and latch blocks
package edge_logic_pkg;
   // ----------------------------------------------------------------
   // widths and depths
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int ADDR_W = 9;
   localparam int TEMP_DEPTH_DEF = 300;
   localparam int MODE_W = 3;
   localparam int MODE_COUNT = 5;

   // ----------------------------------------------------------------
   // register offsets beyond the temporary words
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_PRESET_VOL = 9'h140;
   localparam logic [ADDR_W-1:0] OFF_PRESET_RET = 9'h141;
   localparam logic [ADDR_W-1:0] OFF_MODE = 9'h142;
   localparam logic [ADDR_W-1:0] OFF_COUNT_VOL = 9'h143;
   localparam logic [ADDR_W-1:0] OFF_COUNT_RET = 9'h144;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 9'h145;

   // mode register fields
   localparam int MODE_CODE_LSB = 0;
   localparam int MODE_WIRING_BIT = 8;
   // status register fields
   localparam int ST_VOL_LATCH_BIT = 0;
   localparam int ST_RET_LATCH_BIT = 1;
   localparam int ST_VOL_LT_BIT = 2;
   localparam int ST_RET_LT_BIT = 5;

   // ----------------------------------------------------------------
   // operating mode codes and reset values
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_OVERLOAD = 3'h1;
   localparam logic [MODE_W-1:0] MODE_INDEPENDENT = 3'h2;
   localparam logic [MODE_W-1:0] MODE_REVERSER = 3'h3;
   localparam logic [MODE_W-1:0] MODE_TWO_STEP = 3'h4;
   localparam logic [MODE_W-1:0] MODE_TWO_SPEED = 3'h5;
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h1;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic inc;
      logic dec;
      logic load;
   } counter_in_s;

   typedef struct packed {
      logic [WORD_W-1:0] count;
      logic lt;
      logic eq;
      logic gt;
   } counter_out_s;
endpackage : edge_logic_pkg

//--- rtl/updown_counter.sv
// edge-driven up/down counter with preset compare
`timescale 1ns/1ns
module updown_counter
   import edge_logic_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter bit RETAIN = 1'b0
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire counter_in_s ctl_i,
   input wire logic [WIDTH-1:0] preset_i,
   input wire logic [WIDTH-1:0] restore_i,
   output counter_out_s out_o
);
   if (WIDTH != WORD_W) begin : g_chk
      $error("updown_counter width must match the word width");
   end

   typedef struct packed {
      logic armed;
      logic prev_inc;
      logic prev_dec;
      logic prev_load;
      logic [WIDTH-1:0] count;
   } ctr_state_s;

   ctr_state_s cur;
   ctr_state_s next_cur;
   logic inc_edge;
   logic dec_edge;
   logic load_edge;

   // ----------------------------------------------------------------
   // edge detection and counting
   // ----------------------------------------------------------------
   // compare with previous sample
   assign inc_edge = cur.armed & ctl_i.inc & ~cur.prev_inc;
   assign dec_edge = cur.armed & ctl_i.dec & ~cur.prev_dec;
   assign load_edge = cur.armed & ctl_i.load & ~cur.prev_load;

   always_comb begin
      next_cur = cur;
      next_cur.armed = 1'b1;
      next_cur.prev_inc = ctl_i.inc;
      next_cur.prev_dec = ctl_i.dec;
      next_cur.prev_load = ctl_i.load;
      if (!cur.armed) begin
         next_cur.count = RETAIN ? restore_i : WIDTH'(WORD_ZERO);
      end else if (load_edge) begin
         next_cur.count = preset_i;
      end else if (inc_edge && !dec_edge) begin
         next_cur.count = cur.count + WIDTH'(WORD_ONE);
      end else if (dec_edge && !inc_edge) begin
         next_cur.count = cur.count - WIDTH'(WORD_ONE);
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // preset used for compare
   // one driver for the whole carrier, members filled together
   assign out_o = '{
      count: cur.count,
      lt: cur.count < preset_i,
      eq: cur.count == preset_i,
      gt: cur.count > preset_i
   };

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_CTR_LOAD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      load_edge |=> cur.count == $past(preset_i))
      else $error("load edge did not copy preset");
   AST_CTR_UP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      inc_edge && !dec_edge && !load_edge |=> cur.count == $past(cur.count) + WIDTH'(WORD_ONE))
      else $error("count up failed");
   AST_CTR_DOWN: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      dec_edge && !inc_edge && !load_edge |=> cur.count == $past(cur.count) - WIDTH'(WORD_ONE))
      else $error("count down failed");
   AST_CTR_CANCEL: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      inc_edge && dec_edge && !load_edge |=> $stable(cur.count))
      else $error("simultaneous edges did not cancel");
   AST_CTR_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      $onehot({out_o.lt, out_o.eq, out_o.gt}))
      else $error("compare flags not exclusive");
   AST_CTR_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cur.armed && ctl_i.inc && ctl_i.dec && ctl_i.load ##1 ctl_i.inc && ctl_i.dec && ctl_i.load
      |=> $stable(cur.count))
      else $error("held level counted as an edge");
endmodule : updown_counter

//--- rtl/edge_counter_and_latch_blocks.sv
// counters, edge latches, mode selector and temporary word reader
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
module edge_counter_and_latch_blocks
   import edge_logic_pkg::*;
#(
   parameter int TEMP_DEPTH = TEMP_DEPTH_DEF
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire bus_req_s bus_i,
   output logic [WORD_W-1:0] rdata_o,
   input wire logic [ADDR_W-1:0] temp_index_i,
   output logic [WORD_W-1:0] temp_word_o,
   input wire counter_in_s vol_ctr_i,
   input wire counter_in_s ret_ctr_i,
   output counter_out_s vol_ctr_o,
   output counter_out_s ret_ctr_o,
   input wire logic [WORD_W-1:0] nv_count_i,
   input wire logic [WORD_W-1:0] nv_preset_i,
   input wire logic nv_latch_i,
   output logic [WORD_W-1:0] nv_preset_o,
   input wire logic vol_latch_set_i,
   input wire logic vol_latch_clear_i,
   input wire logic ret_latch_set_i,
   input wire logic ret_latch_clear_i,
   output logic vol_latch_q_o,
   output logic ret_latch_q_o,
   output logic [MODE_COUNT-1:0] mode_run_o,
   output logic three_wire_control_o,
   output logic two_wire_control_o
);
   if (TEMP_DEPTH < 1 || TEMP_DEPTH > int'(OFF_PRESET_VOL)) begin : g_chk
      $error("temporary depth collides with control offsets");
   end

   localparam int VOL = 0;
   localparam int RET = 1;

   typedef struct packed {
      logic [TEMP_DEPTH-1:0][WORD_W-1:0] temp;
      logic [WORD_W-1:0] rdata;
      logic [WORD_W-1:0] temp_word;
      logic [WORD_W-1:0] preset_vol;
      logic [WORD_W-1:0] preset_ret;
      logic [MODE_W-1:0] mode_code;
      logic wiring;
      logic [1:0] latch_q;
      logic [1:0] prev_set;
      logic [1:0] prev_clr;
      logic armed;
   } top_state_s;

   top_state_s cur;
   top_state_s next_cur;
   logic [1:0] set_lvl;
   logic [1:0] clr_lvl;
   logic [1:0] set_edge;
   logic [1:0] clr_edge;
   logic [WORD_W-1:0] status_word;
   logic [WORD_W-1:0] mode_word;

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   // volatile storage, cleared at power-up
   updown_counter #(
      .WIDTH(WORD_W),
      .RETAIN(1'b0)
   ) u_vol_counter (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ctl_i(vol_ctr_i),
      .preset_i(cur.preset_vol),
      .restore_i(WORD_ZERO),
      .out_o(vol_ctr_o)
   );

   // retentive storage, restored from the store
   // the save path is the count output itself, no extra copy
   updown_counter #(
      .WIDTH(WORD_W),
      .RETAIN(1'b1)
   ) u_ret_counter (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ctl_i(ret_ctr_i),
      .preset_i(cur.preset_ret),
      .restore_i(nv_count_i),
      .out_o(ret_ctr_o)
   );

   // ----------------------------------------------------------------
   // latch edges
   // ----------------------------------------------------------------
   assign set_lvl = {ret_latch_set_i, vol_latch_set_i};
   assign clr_lvl = {ret_latch_clear_i, vol_latch_clear_i};
   assign set_edge = {2{cur.armed}} & set_lvl & ~cur.prev_set;
   assign clr_edge = {2{cur.armed}} & clr_lvl & ~cur.prev_clr;

   // ----------------------------------------------------------------
   // read views
   // ----------------------------------------------------------------
   always_comb begin
      status_word = WORD_ZERO;
      status_word[ST_VOL_LATCH_BIT] = cur.latch_q[VOL];
      status_word[ST_RET_LATCH_BIT] = cur.latch_q[RET];
      status_word[ST_VOL_LT_BIT +: 3] = {vol_ctr_o.gt, vol_ctr_o.eq, vol_ctr_o.lt};
      status_word[ST_RET_LT_BIT +: 3] = {ret_ctr_o.gt, ret_ctr_o.eq, ret_ctr_o.lt};
      mode_word = WORD_ZERO;
      mode_word[MODE_CODE_LSB +: MODE_W] = cur.mode_code;
      mode_word[MODE_WIRING_BIT] = cur.wiring;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.armed = 1'b1;
      next_cur.prev_set = set_lvl;
      next_cur.prev_clr = clr_lvl;
      next_cur.rdata = WORD_ZERO;

      // register writes
      if (bus_i.wr) begin
         if (int'(bus_i.addr) < TEMP_DEPTH) begin
            next_cur.temp[bus_i.addr] = bus_i.wdata;
         end else begin
            case (bus_i.addr)
               OFF_PRESET_VOL: begin
                  next_cur.preset_vol = bus_i.wdata;
               end
               OFF_PRESET_RET: begin
                  next_cur.preset_ret = bus_i.wdata;
               end
               OFF_MODE: begin
                  next_cur.mode_code = bus_i.wdata[MODE_CODE_LSB +: MODE_W];
                  next_cur.wiring = bus_i.wdata[MODE_WIRING_BIT];
               end
               default: begin
                  next_cur.rdata = WORD_ZERO;
               end
            endcase
         end
      end

      // register reads, answered in the next cycle only
      if (bus_i.rd) begin
         if (int'(bus_i.addr) < TEMP_DEPTH) begin
            next_cur.rdata = cur.temp[bus_i.addr];
         end else begin
            case (bus_i.addr)
               OFF_PRESET_VOL: begin
                  next_cur.rdata = cur.preset_vol;
               end
               OFF_PRESET_RET: begin
                  next_cur.rdata = cur.preset_ret;
               end
               OFF_MODE: begin
                  next_cur.rdata = mode_word;
               end
               OFF_COUNT_VOL: begin
                  next_cur.rdata = vol_ctr_o.count;
               end
               OFF_COUNT_RET: begin
                  next_cur.rdata = ret_ctr_o.count;
               end
               OFF_STATUS: begin
                  next_cur.rdata = status_word;
               end
               default: begin
                  next_cur.rdata = WORD_ZERO;
               end
            endcase
         end
      end

      if (int'(temp_index_i) < TEMP_DEPTH) begin
         next_cur.temp_word = cur.temp[temp_index_i];
      end else begin
         next_cur.temp_word = WORD_ZERO;
      end

      if (!cur.armed) begin
         next_cur.latch_q[RET] = nv_latch_i;
         next_cur.preset_ret = nv_preset_i;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (clr_edge[i]) begin
               next_cur.latch_q[i] = 1'b0;
            end else if (set_edge[i]) begin
               next_cur.latch_q[i] = 1'b1;
            end
         end
      end
   end

   // reset takes constants only; restore happens after release
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur <= '0;
         cur.mode_code <= MODE_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------------------------------
   // mode selector
   // ----------------------------------------------------------------
   // one run flag per valid code
   always_comb begin
      case (cur.mode_code)
         MODE_OVERLOAD: mode_run_o = 5'h01;
         MODE_INDEPENDENT: mode_run_o = 5'h02;
         MODE_REVERSER: mode_run_o = 5'h04;
         MODE_TWO_STEP: mode_run_o = 5'h08;
         MODE_TWO_SPEED: mode_run_o = 5'h10;
         default: mode_run_o = 5'h00;
      endcase
   end

   assign three_wire_control_o = cur.wiring;
   assign two_wire_control_o = ~cur.wiring;

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_o = cur.rdata;
   assign temp_word_o = cur.temp_word;
   assign vol_latch_q_o = cur.latch_q[VOL];
   assign ret_latch_q_o = cur.latch_q[RET];
   assign nv_preset_o = cur.preset_ret;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_TEMP_READ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      int'(temp_index_i) < TEMP_DEPTH |=> temp_word_o == $past(cur.temp[temp_index_i]))
      else $error("temporary word reader wrong");
   AST_MODE_RUN: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cur.mode_code == MODE_REVERSER |-> mode_run_o == 5'h04)
      else $error("mode run flag wrong");
   AST_MODE_INVALID: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (cur.mode_code == 3'h0 || cur.mode_code > MODE_TWO_SPEED) |-> mode_run_o == 5'h00)
      else $error("invalid mode ran");
   AST_WIRING: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      bus_i.wr && bus_i.addr == OFF_MODE
      |=> three_wire_control_o == $past(bus_i.wdata[MODE_WIRING_BIT]) && two_wire_control_o != three_wire_control_o)
      else $error("wiring style wrong");
   AST_LATCH_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      set_edge[VOL] && !clr_edge[VOL] |=> vol_latch_q_o)
      else $error("set edge did not turn latch on");
   AST_LATCH_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      clr_edge[RET] |=> !ret_latch_q_o)
      else $error("clear edge did not win");
   AST_LATCH_HOLD: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      cur.armed && !set_edge[VOL] && !clr_edge[VOL] |=> $stable(vol_latch_q_o))
      else $error("latch changed without edge");
   AST_POWER_UP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !cur.armed |=> vol_latch_q_o == 1'b0 && ret_latch_q_o == $past(nv_latch_i))
      else $error("power-up handled as an edge");
   AST_READ_ONCE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      bus_i.rd && bus_i.addr == OFF_COUNT_VOL |=> rdata_o == $past(vol_ctr_o.count) ##1 !$past(bus_i.rd) |-> rdata_o == WORD_ZERO)
      else $error("count read wrong");
endmodule : edge_counter_and_latch_blocks

//--- tb/retentive_store.sv
// behavioural non-volatile store beside the retentive counter and latch
`timescale 1ns/1ns
module retentive_store
   import edge_logic_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [WORD_W-1:0] count_save_i,
   input wire logic [WORD_W-1:0] preset_save_i,
   input wire logic latch_save_i,
   output logic [WORD_W-1:0] count_o,
   output logic [WORD_W-1:0] preset_o,
   output logic latch_o
);
   // contents never reset: only a fresh model starts from zero
   logic [WORD_W-1:0] count_q = '0;
   logic [WORD_W-1:0] preset_q = '0;
   logic latch_q = 1'b0;
   logic armed;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         armed <= 1'b0;
      end else begin
         armed <= 1'b1;
      end
   end

   // keep live state
   // skips the arming edge, else the reset state would overwrite the saved one
   always_ff @(posedge clk_sys_i) begin
      if (reset_n_i && armed) begin
         count_q <= count_save_i;
         preset_q <= preset_save_i;
         latch_q <= latch_save_i;
      end
   end

   assign count_o = count_q;
   assign preset_o = preset_q;
   assign latch_o = latch_q;
endmodule : retentive_store

//--- tb/edge_counter_and_latch_blocks_bench.sv
// self-checking bench for counters, latches, mode selector and temp reader
`timescale 1ns/1ns
module edge_counter_and_latch_blocks_bench
   import edge_logic_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   bus_req_s bus_i = '0;
   logic [ADDR_W-1:0] temp_index_i = '0;
   counter_in_s vol_ctr_i = '0;
   counter_in_s ret_ctr_i = '0;
   logic vol_set = 1'b0;
   logic vol_clr = 1'b0;
   logic ret_set = 1'b0;
   logic ret_clr = 1'b0;
   logic [WORD_W-1:0] rdata_o, temp_word_o, nv_count, nv_preset, nv_preset_o;
   counter_out_s vol_ctr_o, ret_ctr_o;
   logic nv_latch, vol_latch_q_o, ret_latch_q_o, three_w, two_w;
   logic [MODE_COUNT-1:0] mode_run_o;
   int fails = 0;
   int checks_done = 0;

   edge_counter_and_latch_blocks dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .bus_i(bus_i), .rdata_o(rdata_o), .temp_index_i(temp_index_i),
      .temp_word_o(temp_word_o), .vol_ctr_i(vol_ctr_i), .ret_ctr_i(ret_ctr_i),
      .vol_ctr_o(vol_ctr_o), .ret_ctr_o(ret_ctr_o), .nv_count_i(nv_count),
      .nv_preset_i(nv_preset), .nv_latch_i(nv_latch), .nv_preset_o(nv_preset_o),
      .vol_latch_set_i(vol_set), .vol_latch_clear_i(vol_clr),
      .ret_latch_set_i(ret_set), .ret_latch_clear_i(ret_clr),
      .vol_latch_q_o(vol_latch_q_o), .ret_latch_q_o(ret_latch_q_o),
      .mode_run_o(mode_run_o), .three_wire_control_o(three_w),
      .two_wire_control_o(two_w));

   retentive_store store (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .count_save_i(ret_ctr_o.count), .preset_save_i(nv_preset_o),
      .latch_save_i(ret_latch_q_o), .count_o(nv_count), .preset_o(nv_preset),
      .latch_o(nv_latch));

   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic final_report;
      if (fails == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : wait_cyc

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge clk_sys_i);
      bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      bus_i <= '0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
      @(posedge clk_sys_i);
      bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
      @(posedge clk_sys_i);
      bus_i <= '0;
      #1;
      chk(rdata_o, exp);
   endtask : rdchk

   task automatic ctr_chk(input bit ret, input logic [15:0] c, input logic [15:0] p);
      counter_out_s o;
      o = ret ? ret_ctr_o : vol_ctr_o;
      chk(o.count, c);
      chk({13'h0, o.lt, o.eq, o.gt}, {13'h0, c < p, c == p, c > p});
   endtask : ctr_chk

   // held two cycles so either edge latency is covered
   task automatic pulse_ctr(input bit ret, input logic [2:0] v);
      @(posedge clk_sys_i);
      if (ret) ret_ctr_i <= counter_in_s'(v);
      else vol_ctr_i <= counter_in_s'(v);
      repeat (2) @(posedge clk_sys_i);
      ret_ctr_i <= '0;
      vol_ctr_i <= '0;
      wait_cyc(2);
   endtask : pulse_ctr

   task automatic lat(input bit ret, input bit s, input bit c);
      @(posedge clk_sys_i);
      if (ret) {ret_set, ret_clr} <= {s, c};
      else {vol_set, vol_clr} <= {s, c};
      repeat (2) @(posedge clk_sys_i);
      {ret_set, ret_clr, vol_set, vol_clr} <= 4'h0;
      wait_cyc(2);
   endtask : lat

   task automatic do_reset;
      @(posedge clk_sys_i);
      reset_n_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      wait_cyc(3);
   endtask : do_reset

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic scn_reset_vals;
      ctr_chk(1'b0, 16'h0000, 16'h0000);
      chk({15'h0, vol_latch_q_o}, 16'h0000);
      chk({11'h0, mode_run_o}, 16'h0001);
      chk({14'h0, three_w, two_w}, 16'h0001);
   endtask : scn_reset_vals

   task automatic scn_temp;
      wr(9'h000, 16'ha5a5);
      wr(9'h12b, 16'hffff);
      wr(9'h12c, 16'h1234);
      rdchk(9'h12b, 16'hffff);
      rdchk(9'h12c, 16'h0000);
      rdchk(9'h1ff, 16'h0000);
      @(posedge clk_sys_i);
      temp_index_i <= 9'h000;
      wait_cyc(2);
      chk(temp_word_o, 16'ha5a5);
      @(posedge clk_sys_i);
      temp_index_i <= 9'h12b;
      wait_cyc(2);
      chk(temp_word_o, 16'hffff);
      @(posedge clk_sys_i);
      temp_index_i <= 9'h12c;
      wait_cyc(2);
      chk(temp_word_o, 16'h0000);
   endtask : scn_temp

   // every code and both wiring styles, invalid codes run nothing
   task automatic scn_mode;
      logic [15:0] v;
      logic [2:0] c;
      for (int k = 0; k < 16; k++) begin
         c = k[2:0];
         v = {7'h0, k[3], 5'h0, c};
         wr(OFF_MODE, v);
         wait_cyc(1);
         chk({11'h0, mode_run_o}, (c >= 1 && c <= 5) ? 16'h1 << (c - 1) : 16'h0);
         chk({14'h0, three_w, two_w}, {14'h0, k[3], ~k[3]});
         rdchk(OFF_MODE, v);
      end
   endtask : scn_mode

   task automatic scn_counter(input bit ret);
      logic [ADDR_W-1:0] pa;
      logic [ADDR_W-1:0] ca;
      pa = ret ? OFF_PRESET_RET : OFF_PRESET_VOL;
      ca = ret ? OFF_COUNT_RET : OFF_COUNT_VOL;
      wr(pa, 16'hffff);
      pulse_ctr(ret, 3'b001);
      ctr_chk(ret, 16'hffff, 16'hffff);
      pulse_ctr(ret, 3'b100);
      ctr_chk(ret, 16'h0000, 16'hffff);
      pulse_ctr(ret, 3'b010);
      ctr_chk(ret, 16'hffff, 16'hffff);
      wr(pa, 16'h0005);
      wait_cyc(1);
      ctr_chk(ret, 16'hffff, 16'h0005);
      pulse_ctr(ret, 3'b101);
      ctr_chk(ret, 16'h0005, 16'h0005);
      pulse_ctr(ret, 3'b110);
      ctr_chk(ret, 16'h0005, 16'h0005);
      @(posedge clk_sys_i);
      if (ret) ret_ctr_i <= counter_in_s'(3'b100);
      else vol_ctr_i <= counter_in_s'(3'b100);
      wait_cyc(6);
      ctr_chk(ret, 16'h0006, 16'h0005);
      @(posedge clk_sys_i);
      ret_ctr_i <= '0;
      vol_ctr_i <= '0;
      wr(ca, 16'h1234);
      rdchk(ca, 16'h0006);
      pulse_ctr(ret, 3'b010);
      ctr_chk(ret, 16'h0005, 16'h0005);
   endtask : scn_counter

   // clear pulses while set stays high: the held set must not act again
   task automatic scn_latch_held;
      @(posedge clk_sys_i);
      vol_set <= 1'b1;
      wait_cyc(3);
      chk({15'h0, vol_latch_q_o}, 16'h0001);
      @(posedge clk_sys_i);
      vol_clr <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      vol_clr <= 1'b0;
      wait_cyc(4);
      chk({15'h0, vol_latch_q_o}, 16'h0000);
      @(posedge clk_sys_i);
      vol_set <= 1'b0;
      wait_cyc(2);
      chk({15'h0, vol_latch_q_o}, 16'h0000);
   endtask : scn_latch_held

   task automatic scn_latch(input bit ret);
      lat(ret, 1'b1, 1'b0);
      chk({15'h0, ret ? ret_latch_q_o : vol_latch_q_o}, 16'h0001);
      lat(ret, 1'b0, 1'b1);
      chk({15'h0, ret ? ret_latch_q_o : vol_latch_q_o}, 16'h0000);
      wait_cyc(5);
      chk({15'h0, ret ? ret_latch_q_o : vol_latch_q_o}, 16'h0000);
      lat(ret, 1'b1, 1'b1);
      chk({15'h0, ret ? ret_latch_q_o : vol_latch_q_o}, 16'h0000);
      lat(ret, 1'b1, 1'b0);
      chk({15'h0, ret ? ret_latch_q_o : vol_latch_q_o}, 16'h0001);
   endtask : scn_latch

   // second power-up with an up input held high across the release
   task automatic scn_retain;
      rdchk(OFF_STATUS, 16'h004b);
      @(posedge clk_sys_i);
      vol_ctr_i <= counter_in_s'(3'b100);
      do_reset;
      ctr_chk(1'b0, 16'h0000, 16'h0000);
      @(posedge clk_sys_i);
      vol_ctr_i <= '0;
      ctr_chk(1'b1, 16'h0005, 16'h0005);
      chk(nv_preset_o, 16'h0005);
      rdchk(OFF_PRESET_RET, 16'h0005);
      chk({15'h0, ret_latch_q_o}, 16'h0001);
      chk({15'h0, vol_latch_q_o}, 16'h0000);
      rdchk(OFF_PRESET_VOL, 16'h0000);
      rdchk(OFF_COUNT_VOL, 16'h0000);
   endtask : scn_retain

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      final_report();
   end

   initial begin
      repeat (10) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      wait_cyc(3);
      scn_reset_vals();
      scn_temp();
      scn_mode();
      scn_counter(1'b0);
      scn_counter(1'b1);
      scn_latch_held();
      scn_latch(1'b1);
      scn_latch(1'b0);
      scn_retain();
      final_report();
   end
endmodule : edge_counter_and_latch_blocks_bench
